//--- cbr_pkg.sv
package cbr_pkg;

   // ****************************************************************
   // Opcode bytes
   // ****************************************************************
   localparam logic [7:0] CBR_PFX_ROT = 8'hCB;
   localparam logic [7:0] CBR_PFX_IDX1 = 8'hDD;
   localparam logic [7:0] CBR_PFX_IDX2 = 8'hFD;
   localparam logic [4:0] CBR_OP_LCIRC = 5'h00;
   localparam logic [4:0] CBR_OP_RCIRC = 5'h01;
   localparam logic [4:0] CBR_OP_LCARRY = 5'h02;
   localparam logic [4:0] CBR_OP_RCARRY = 5'h03;
   localparam logic [2:0] CBR_MEM_CODE = 3'h6;

   // ****************************************************************
   // T-states per machine cycle
   // ****************************************************************
   localparam logic [2:0] CBR_T_FETCH = 3'h4;
   localparam logic [2:0] CBR_T_DISP = 3'h3;
   localparam logic [2:0] CBR_T_IDXFN = 3'h5;
   localparam logic [2:0] CBR_T_READ = 3'h4;
   localparam logic [2:0] CBR_T_WRITE = 3'h3;

   // ****************************************************************
   // Flag byte layout
   // ****************************************************************
   localparam int CBR_F_S = 7;
   localparam int CBR_F_Z = 6;
   localparam int CBR_F_H = 4;
   localparam int CBR_F_PV = 2;
   localparam int CBR_F_N = 1;
   localparam int CBR_F_C = 0;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [3:0] {
      CBR_ST_IDLE = 4'h1,
      CBR_ST_FETCH = 4'h2,
      CBR_ST_READ = 4'h4,
      CBR_ST_WRITE = 4'h8
   } cbr_state_t;

   // Which byte the current fetch cycle brings in
   typedef enum logic [1:0] {
      CBR_B_FIRST = 2'h0,
      CBR_B_ROTPFX = 2'h1,
      CBR_B_DISP = 2'h2,
      CBR_B_FUNC = 2'h3
   } cbr_byte_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic rd;
      logic wr;
   } cbr_mem_t;

   typedef struct packed {
      logic reg_we;
      logic [2:0] reg_sel;
      logic [7:0] reg_data;
      logic flag_we;
      logic [7:0] flags;
      logic done;
      logic bad_op;
   } cbr_result_t;

endpackage : cbr_pkg

//--- cbr_rotate_unit.sv
// Overview of operation
// - Index form bytes: prefix, rotate prefix, displacement, function.
// - Indexed address is index register plus sign-extended displacement.
// - Left-circular: shift left, old bit 7 to carry and bit 0.
// - Register 8T (4,4); pointer 15T (4,4,4,3); indexed 23T (4,4,3,5,4,3).
// - Other three rotates accept register, pointer, both indexed operands.
// - Register code B..L are 000..101, A is 111; 110 means memory.
// - Left through carry: old bit 7 to carry, old carry to bit 0.
// - Right-circular: shift right, old bit 0 to carry and bit 7.
// - Right through carry: old bit 0 to carry, old carry to bit 7.
// - Right memory forms end 0E/1E; indexed add prefix and displacement.
// - Sign follows result bit 7; half-carry and subtract always cleared.
// - Zero flag set when the eight-bit result is zero.
// - Parity flag set when the result has an even count of ones.
// - Left-circular function byte is 00000rrr; pointer memory form is 06.
`timescale 1ns/1ps
`default_nettype none

module cbr_rotate_unit
   import cbr_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic start,
   input wire logic [7:0] code_byte,
   input wire logic [63:0] reg_file,
   input wire logic [15:0] index_base_first,
   input wire logic [15:0] index_base_second,
   input wire logic [15:0] pointer_pair,
   input wire logic [7:0] flag_in,
   input wire logic [7:0] mem_rdata,
   output logic busy,
   output logic code_take,
   output cbr_mem_t mem,
   output cbr_result_t res
);

   // ****************************************************************
   // Datapath functions
   // ****************************************************************
   function automatic logic [8:0] rot(input logic [1:0] op,
                                      input logic [7:0] v,
                                      input logic cin);
      logic [8:0] r;
      r = '0;
      unique case (op)
         CBR_OP_LCIRC[1:0]: r = {v[7], v[6:0], v[7]};
         CBR_OP_RCIRC[1:0]: r = {v[0], v[0], v[7:1]};
         CBR_OP_LCARRY[1:0]: r = {v[7], v[6:0], cin};
         CBR_OP_RCARRY[1:0]: r = {v[0], cin, v[7:1]};
      endcase
      return r;
   endfunction : rot

   function automatic logic [7:0] flags_of(input logic [8:0] cr);
      logic [7:0] f;
      f = 8'h00;
      f[CBR_F_S] = cr[7];
      f[CBR_F_Z] = (cr[7:0] == 8'h00);
      f[CBR_F_PV] = ~^cr[7:0];
      f[CBR_F_H] = 1'b0;
      f[CBR_F_N] = 1'b0;
      f[CBR_F_C] = cr[8];
      return f;
   endfunction : flags_of

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      cbr_state_t st;
      cbr_byte_t step;
      logic [2:0] tcnt;
      logic [2:0] tlen;
      logic indexed;
      logic second;
      logic [7:0] disp;
      logic [7:0] wdata;
      logic [8:0] cres;
      logic take;
      cbr_mem_t mem;
      cbr_result_t res;
   } cbr_core_t;

   cbr_core_t s_q;
   cbr_core_t s_d;

   logic last_t;
   logic [15:0] base;
   logic [8:0] cr_reg;
   logic [8:0] cr_mem;

   assign last_t = (s_q.tcnt == s_q.tlen - 3'h1);
   assign base = s_q.second ? index_base_second : index_base_first;
   assign cr_reg = rot(code_byte[4:3], reg_file[code_byte[2:0]*8 +: 8],
                       flag_in[CBR_F_C]);
   assign cr_mem = rot(s_q.res.reg_sel[1:0], mem_rdata, flag_in[CBR_F_C]);

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   always_comb begin
      s_d = s_q;
      s_d.take = 1'b0;
      s_d.res.reg_we = 1'b0;
      s_d.res.flag_we = 1'b0;
      s_d.res.done = 1'b0;
      s_d.res.bad_op = 1'b0;
      s_d.tcnt = last_t ? 3'h0 : s_q.tcnt + 3'h1;
      unique case (s_q.st)
         CBR_ST_IDLE: begin
            s_d.tcnt = 3'h0;
            if (start) begin
               s_d.st = CBR_ST_FETCH;
               s_d.step = CBR_B_FIRST;
               s_d.tlen = CBR_T_FETCH;
               s_d.indexed = 1'b0;
               s_d.second = 1'b0;
            end
         end
         CBR_ST_FETCH: begin
            if (last_t) begin
               s_d.take = 1'b1;
               unique case (s_q.step)
                  CBR_B_FIRST: begin
                     s_d.tlen = CBR_T_FETCH;
                     if (code_byte == CBR_PFX_ROT) begin
                        s_d.step = CBR_B_FUNC;
                     end else if (code_byte == CBR_PFX_IDX1 ||
                                  code_byte == CBR_PFX_IDX2) begin
                        s_d.step = CBR_B_ROTPFX;
                        s_d.indexed = 1'b1;
                        s_d.second = (code_byte == CBR_PFX_IDX2);
                     end else begin
                        s_d.st = CBR_ST_IDLE;
                        s_d.res.bad_op = 1'b1;
                     end
                  end
                  CBR_B_ROTPFX: begin
                     s_d.step = CBR_B_DISP;
                     s_d.tlen = CBR_T_DISP;
                     if (code_byte != CBR_PFX_ROT) begin
                        s_d.st = CBR_ST_IDLE;
                        s_d.res.bad_op = 1'b1;
                     end
                  end
                  CBR_B_DISP: begin
                     s_d.disp = code_byte;
                     s_d.step = CBR_B_FUNC;
                     s_d.tlen = CBR_T_IDXFN;
                  end
                  CBR_B_FUNC: begin
                     // Opcodes 00..1F cover all four rotates
                     s_d.res.reg_sel = code_byte[2:0];
                     s_d.res.reg_data = cr_reg[7:0];
                     s_d.res.flags = flags_of(cr_reg);
                     if (code_byte[7:5] != 3'h0) begin
                        s_d.st = CBR_ST_IDLE;
                        s_d.res.bad_op = 1'b1;
                     end else if (code_byte[2:0] == CBR_MEM_CODE) begin
                        s_d.st = CBR_ST_READ;
                        s_d.tlen = CBR_T_READ;
                        s_d.res.reg_sel = {1'b0, code_byte[4:3]};
                        s_d.mem.rd = 1'b1;
                        s_d.mem.addr = pointer_pair;
                        if (s_q.indexed) begin
                           s_d.mem.addr = base +
                              {{8{s_q.disp[7]}}, s_q.disp};
                        end
                     end else if (s_q.indexed) begin
                        // Indexed prefix needs memory code 110
                        s_d.st = CBR_ST_IDLE;
                        s_d.res.bad_op = 1'b1;
                     end else begin
                        s_d.st = CBR_ST_IDLE;
                        s_d.res.reg_we = 1'b1;
                        s_d.res.flag_we = 1'b1;
                        s_d.res.done = 1'b1;
                     end
                  end
               endcase
            end
         end
         CBR_ST_READ: begin
            if (last_t) begin
               s_d.st = CBR_ST_WRITE;
               s_d.tlen = CBR_T_WRITE;
               s_d.mem.rd = 1'b0;
               s_d.mem.wr = 1'b1;
               s_d.mem.wdata = cr_mem[7:0];
               s_d.cres = cr_mem;
            end
         end
         CBR_ST_WRITE: begin
            if (last_t) begin
               s_d.st = CBR_ST_IDLE;
               s_d.mem.wr = 1'b0;
               s_d.res.reg_data = s_q.cres[7:0];
               s_d.res.flags = flags_of(s_q.cres);
               s_d.res.flag_we = 1'b1;
               s_d.res.done = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '{st: CBR_ST_IDLE, step: CBR_B_FIRST, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign busy = (s_q.st != CBR_ST_IDLE);
   assign code_take = s_q.take;
   assign mem = s_q.mem;
   assign res = s_q.res;

endmodule : cbr_rotate_unit

`default_nettype wire

//--- cbr_rotate_unit_properties.sv
`timescale 1ns/1ps
`default_nettype none
module cbr_rotate_unit_properties
   import cbr_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic start,
   input wire logic busy,
   input wire logic code_take,
   input wire cbr_mem_t mem,
   input wire cbr_result_t res
);
   logic [4:0] cnt_q;
   logic [4:0] cnt_d;
   // Counts busy cycles of the running instruction
   always_comb cnt_d = busy ? cnt_q + 5'h01 : 5'h00;
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) cnt_q <= 5'h00;
      else cnt_q <= cnt_d;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   exec_time_a: assert property (res.done |-> cnt_q inside
      {5'h08, 5'h0F, 5'h17}) else $error("bad instruction length");
   start_busy_a: assert property (start && !busy |=> busy)
      else $error("start not taken");
   take_gap_a: assert property (code_take |=> !code_take [*2])
      else $error("fetch cycle too short");
   rd_len_a: assert property ($rose(mem.rd) |->
      mem.rd [*4] ##1 !mem.rd) else $error("read cycle length");
   wr_len_a: assert property ($fell(mem.rd) |->
      mem.wr [*3] ##1 !mem.wr) else $error("write cycle length");
   same_addr_a: assert property ($fell(mem.rd) |->
      mem.addr == $past(mem.addr)) else $error("write address moved");
   wb_done_a: assert property ($fell(mem.wr) |->
      res.done && res.flag_we && !res.reg_we)
      else $error("memory form end");
   flag_fix_a: assert property (res.flag_we |->
      (res.flags & 8'h3A) == 8'h00) else $error("fixed flags set");
   sign_zero_a: assert property (res.flag_we |->
      res.flags[7] == res.reg_data[7] &&
      res.flags[6] == (res.reg_data == 8'h00))
      else $error("sign or zero flag");
   parity_a: assert property (res.flag_we |->
      res.flags[2] == ~^res.reg_data) else $error("parity flag");
   bad_quiet_a: assert property (res.bad_op |->
      !(res.reg_we || res.flag_we || res.done || mem.wr))
      else $error("write on illegal code");
endmodule : cbr_rotate_unit_properties
bind cbr_rotate_unit cbr_rotate_unit_properties u_props (.mclk(mclk),
   .arst_n(arst_n), .start(start), .busy(busy), .code_take(code_take),
   .mem(mem), .res(res));
`default_nettype wire

//--- cbr_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module cbr_mem_model
   import cbr_pkg::*;
(
   input wire logic mclk,
   input wire cbr_mem_t mem,
   input wire logic [7:0] pat,
   output logic [7:0] rdata = 8'h00,
   output logic [15:0] wa = 16'h0000,
   output logic [7:0] wd = 8'h00
);
   // Data bus toggles when not read so a stale byte never looks valid
   always @(posedge mclk) begin
      if (mem.rd) rdata <= pat;
      else rdata <= ~rdata;
      if (mem.wr) begin
         wa <= mem.addr;
         wd <= mem.wdata;
      end
   end
endmodule : cbr_mem_model
`default_nettype wire

//--- tb_cbr_rotate_unit.sv
`timescale 1ns/1ps
`default_nettype none
module tb_cbr_rotate_unit
   import cbr_pkg::*;
;
   logic mclk = 1'b0, arst_n = 1'b0, start = 1'b0;
   logic [7:0] code_byte = 8'h00, flag_in = 8'h00, pat = 8'h00;
   logic [63:0] reg_file = 64'h0;
   logic [15:0] index_base_first = 16'h0, index_base_second = 16'h0;
   logic [15:0] pointer_pair = 16'h0, wa;
   logic [7:0] rdata, wd;
   logic busy, code_take;
   cbr_mem_t mem;
   cbr_result_t res;
   logic [31:0] rnd = 32'hA9C120F2;
   logic [51:0] q[$];
   logic [51:0] e;
   logic [31:0] bad_t[4] = '{32'h0, 32'hDD000000, 32'hFDCB0107, 32'hCB200000};
   int cyc = 0, error_cnt = 0, samples_checked = 0;
   always #5 mclk = ~mclk;
   cbr_rotate_unit dut (.mclk(mclk), .arst_n(arst_n), .start(start),
      .code_byte(code_byte), .reg_file(reg_file),
      .index_base_first(index_base_first),
      .index_base_second(index_base_second), .pointer_pair(pointer_pair),
      .flag_in(flag_in), .mem_rdata(rdata), .busy(busy),
      .code_take(code_take), .mem(mem), .res(res));
   cbr_mem_model u_mem (.mclk(mclk), .mem(mem), .pat(pat), .rdata(rdata),
      .wa(wa), .wd(wd));
   // ****************************************************************
   // Tasks
   // ****************************************************************
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   task automatic wrap_up();
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [15:0] s, input logic [15:0] x);
      samples_checked++;
      if (s !== x) begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, s, x);
      end
   endtask : chk
   // Feeds bytes in order, moving on after each byte is taken
   task automatic drv(input logic [31:0] bs);
      int k, n;
      k = 0;
      n = 0;
      start = 1'b1;
      code_byte = bs[31:24];
      @(posedge mclk);
      #1 start = 1'b0;
      while (res.done !== 1'b1 && res.bad_op !== 1'b1 && n < 40) begin
         if (code_take === 1'b1 && k < 3) k++;
         code_byte = bs[31 - 8 * k -: 8];
         @(posedge mclk);
         #1 n++;
      end
      if (n >= 40) begin
         error_cnt++;
         wrap_up();
      end
   endtask : drv
   task automatic run(input logic [1:0] op, input logic [1:0] fm);
      logic [7:0] v, r, d, fn;
      logic [2:0] rc;
      logic [15:0] a;
      logic co;
      rnd = lfsr(rnd);
      v = rnd[7:0];
      d = rnd[15:8];
      rc = (rnd[18:16] == 3'h6) ? 3'h7 : rnd[18:16];
      reg_file = {rnd, ~rnd};
      reg_file[rc * 8 +: 8] = v;
      pointer_pair = rnd[31:16];
      index_base_first = rnd[23:8];
      index_base_second = ~rnd[15:0];
      flag_in = rnd[31:24];
      pat = v;
      case (op)
         2'h0: {co, r} = {v[7], v[6:0], v[7]};
         2'h1: {co, r} = {v[0], v[0], v[7:1]};
         2'h2: {co, r} = {v[7], v[6:0], flag_in[0]};
         default: {co, r} = {v[0], flag_in[0], v[7:1]};
      endcase
      fn = {3'h0, op, (fm == 2'h0) ? rc : 3'h6};
      a = (fm == 2'h1) ? pointer_pair : ((fm == 2'h2) ? index_base_first
         : index_base_second) + {{8{d[7]}}, d};
      // Memory forms report the operation code in the select field
      q.push_back({(fm == 2'h0) ? rc : {1'b0, op}, fm != 2'h0, a, r,
         r[7], r == 8'h00, 3'h0, ~^r, 1'b0, co,
         16'(cyc) + ((fm == 2'h0) ? 16'h9 : (fm == 2'h1) ? 16'h10
         : 16'h18)});
      drv(fm[1] ? {fm[0] ? CBR_PFX_IDX2 : CBR_PFX_IDX1, CBR_PFX_ROT, d, fn}
         : {CBR_PFX_ROT, fn, 16'h0000});
   endtask : run
   // ****************************************************************
   // Result monitor and main sequence
   // ****************************************************************
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (res.done === 1'b1) begin
         e = (q.size() > 0) ? q.pop_front() : ~52'h0;
         chk({12'h000, res.reg_we, res.reg_sel}, {12'h000, !e[48], e[51:49]});
         chk({8'h00, res.reg_data}, {8'h00, e[31:24]});
         chk({8'h00, res.flags}, {8'h00, e[23:16]});
         chk(16'(cyc), e[15:0]);
         if (e[48]) begin
            chk(wa, e[47:32]);
            chk({8'h00, wd}, {8'h00, e[31:24]});
         end
      end
   end
   initial begin
      repeat (3) @(posedge mclk);
      #1 arst_n = 1'b1;
      for (int i = 0; i < 32; i++) run(i[1:0], i[3:2]);
      // Reset in mid-instruction drops the unit back to idle at once
      start = 1'b1;
      code_byte = CBR_PFX_IDX1;
      repeat (6) @(posedge mclk);
      #1 start = 1'b0;
      arst_n = 1'b0;
      #1 chk({12'h0, busy, code_take, mem.rd, res.done}, 16'h0000);
      @(posedge mclk);
      #1 arst_n = 1'b1;
      run(2'h1, 2'h2);
      foreach (bad_t[j]) begin
         drv(bad_t[j]);
         chk({15'h0000, res.bad_op}, 16'h0001);
         @(posedge mclk);
         #1;
      end
      run(2'h2, 2'h3);
      repeat (2) @(posedge mclk);
      chk(16'(q.size()), 16'h0000);
      wrap_up();
   end
endmodule : tb_cbr_rotate_unit
`default_nettype wire
